// file: inc/arinc_word_transmitter_map.svh
// Offsets, field positions, reset values and timing counts of the ARINC word transmitter
`ifndef ARINC_WORD_TRANSMITTER_MAP_SVH
`define ARINC_WORD_TRANSMITTER_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AWT_CTRL_ADDR 4'h0
`define AWT_STAT_ADDR 4'h1
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define AWT_CTRL_LOOPBACK 5
`define AWT_CTRL_REPEAT 6
`define AWT_CTRL_PARITY 12
`define AWT_CTRL_RATE 13
`define AWT_CTRL_RESET 16'h0020
// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define AWT_STAT_READY 0
`define AWT_STAT_COUNT_LSB 1
`define AWT_STAT_BUSY 5
`define AWT_STAT_RX1 6
`define AWT_STAT_RX2 7
// ----------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------
`define AWT_FIFO_DEPTH 8
`define AWT_WORD_BITS 31
`define AWT_LAST_BIT 5'h1F
`define AWT_HALF_HI 9'h005
`define AWT_HALF_LO 9'h028
`define AWT_GAP_HI 9'h028
`define AWT_GAP_LO 9'h140
`define AWT_CLK_NS 10
`define AWT_READY_MAX_NS 840
`define AWT_READY_MAX_CYC (`AWT_READY_MAX_NS / `AWT_CLK_NS)
`endif

// file: inc/arinc_tx_pkg.sv
// Types shared by the ARINC word transmitter
package arinc_tx_pkg;
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_DATA,
    TX_NULL,
    TX_GAP
  } tx_state_t;
  typedef logic [30:0] tx_word_t;
endpackage : arinc_tx_pkg

// file: verilog/arinc_word_transmitter.sv
// ARINC 429 transmit path with FIFO, receive latches, loopback and repeater
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "arinc_word_transmitter_map.svh"
module arinc_word_transmitter
  import arinc_tx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Transmit load
  input wire logic [15:0] load_data,
  input wire logic first_byte_load_strobe,
  input wire logic second_byte_load_strobe,
  input wire logic transmit_enable,
  output logic tx_ready,
  // Receive side
  input wire logic [31:0] rx1_word,
  input wire logic [31:0] rx2_word,
  input wire logic rx1_word_done,
  input wire logic rx2_word_done,
  input wire logic rx1_read_strobe,
  input wire logic rx2_read_strobe,
  input wire logic rx_byte_sel,
  output logic [15:0] rx_read_data,
  output logic rx1_word_available,
  output logic rx2_word_available,
  // Receiver logic inputs
  input wire logic rx1_line_true,
  input wire logic rx1_line_comp,
  input wire logic rx2_line_true,
  input wire logic rx2_line_comp,
  output logic rx1_logic_true,
  output logic rx1_logic_comp,
  output logic rx2_logic_true,
  output logic rx2_logic_comp,
  // Serial and line outputs
  output logic serial_out_true,
  output logic serial_out_comp,
  output logic line_out_a,
  output logic line_out_b,
  output logic line_slope_slow
);
  // --------------------------------------------------------------------
  // Byte packing
  // --------------------------------------------------------------------
  function automatic logic [15:0] byte1_of(input logic [31:0] w);
    byte1_of = {w[12], w[11], w[10], w[9], w[8], w[30], w[29], w[31],
                w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
  endfunction : byte1_of

  function automatic logic [15:0] byte2_of(input logic [31:0] w);
    byte2_of = w[28:13];
  endfunction : byte2_of

  function automatic tx_word_t word_of(input logic [15:0] b1, input logic [15:0] b2);
    word_of = {b1[10], b1[9], b2, b1[15], b1[14], b1[13], b1[12], b1[11],
               b1[0], b1[1], b1[2], b1[3], b1[4], b1[5], b1[6], b1[7]};
  endfunction : word_of

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic parity_invert_bit;
  logic loopback_test_bit;
  logic tx_rate_select_bit;
  logic repeat_mode;
  wire ctrl_wr = reg_write && (reg_addr == `AWT_CTRL_ADDR);
  assign parity_invert_bit = ctrl_q[`AWT_CTRL_PARITY];
  assign loopback_test_bit = ctrl_q[`AWT_CTRL_LOOPBACK];
  assign tx_rate_select_bit = ctrl_q[`AWT_CTRL_RATE];
  assign repeat_mode = ctrl_q[`AWT_CTRL_REPEAT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `AWT_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------
  // Receive latches
  // --------------------------------------------------------------------
  // Each channel latches and clears on its own; nothing here waits on the transmitter.
  logic [31:0] rx_word_in [2];
  logic [1:0] rx_done;
  logic [1:0] rx_rd;
  logic [31:0] rx_lat_q [2];
  logic [1:0] avail_q;
  logic [1:0] got_lo_q;
  logic [1:0] got_hi_q;
  logic [1:0] rep_push_ch;
  assign rx_word_in[0] = rx1_word;
  assign rx_word_in[1] = rx2_word;
  assign rx_done = {rx2_word_done, rx1_word_done};
  assign rx_rd = {rx2_read_strobe, rx1_read_strobe};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_rx
      wire rd_lo = rx_rd[ch] && !rx_byte_sel;
      wire rd_hi = rx_rd[ch] && rx_byte_sel;
      wire both_done = (got_lo_q[ch] || rd_lo) && (got_hi_q[ch] || rd_hi);
      // Lower byte first arms the repeater; the upper byte then queues the word
      assign rep_push_ch[ch] = repeat_mode && rd_hi && got_lo_q[ch];
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          rx_lat_q[ch] <= 32'h00000000;
          avail_q[ch] <= 1'b0;
          got_lo_q[ch] <= 1'b0;
          got_hi_q[ch] <= 1'b0;
        end else if (rx_done[ch]) begin
          // A new word overwrites unread data and wins over a clear
          rx_lat_q[ch] <= rx_word_in[ch];
          avail_q[ch] <= 1'b1;
          got_lo_q[ch] <= 1'b0;
          got_hi_q[ch] <= 1'b0;
        end else if (both_done) begin
          avail_q[ch] <= 1'b0;
          got_lo_q[ch] <= 1'b0;
          got_hi_q[ch] <= 1'b0;
        end else begin
          got_lo_q[ch] <= got_lo_q[ch] || rd_lo;
          got_hi_q[ch] <= got_hi_q[ch] || rd_hi;
        end
      end
    end
  endgenerate

  wire [31:0] rd_word = rx2_read_strobe ? rx_lat_q[1] : rx_lat_q[0];
  wire [15:0] rd_byte = rx_byte_sel ? byte2_of(rd_word) : byte1_of(rd_word);
  wire any_rd = rx1_read_strobe || rx2_read_strobe;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_read_data <= 16'h0000;
    end else if (any_rd) begin
      rx_read_data <= rd_byte;
    end
  end
  assign rx1_word_available = avail_q[0];
  assign rx2_word_available = avail_q[1];

  // --------------------------------------------------------------------
  // Host load path
  // --------------------------------------------------------------------
  logic pl1_prev_q;
  logic pl2_prev_q;
  logic byte1_valid_q;
  logic [15:0] byte1_q;
  wire pl1_rise = first_byte_load_strobe && !pl1_prev_q;
  wire pl2_rise = second_byte_load_strobe && !pl2_prev_q;
  // A second byte with no first byte before it is ignored
  wire host_push = pl2_rise && byte1_valid_q;
  wire rep_push = |rep_push_ch;
  wire [31:0] rep_word = rep_push_ch[1] ? rx_lat_q[1] : rx_lat_q[0];
  wire push_req = host_push || rep_push;
  wire tx_word_t push_word = host_push ? word_of(byte1_q, load_data) : rep_word[30:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pl1_prev_q <= 1'b0;
      pl2_prev_q <= 1'b0;
      byte1_valid_q <= 1'b0;
      byte1_q <= 16'h0000;
    end else begin
      pl1_prev_q <= first_byte_load_strobe;
      pl2_prev_q <= second_byte_load_strobe;
      if (pl1_rise) begin
        byte1_q <= load_data;
        byte1_valid_q <= 1'b1;
      end else if (pl2_rise) begin
        byte1_valid_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // FIFO
  // --------------------------------------------------------------------
  tx_word_t mem_q [`AWT_FIFO_DEPTH];
  logic [2:0] wr_ptr_q;
  logic [2:0] rd_ptr_q;
  logic [3:0] count_q;
  logic pop;
  wire fifo_full = (count_q == 4'(`AWT_FIFO_DEPTH));
  wire fifo_empty = (count_q == 4'h0);
  wire push = push_req && !fifo_full;
  wire [3:0] count_d = count_q + {3'h0, push} - {3'h0, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= push_word;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      count_q <= 4'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q + {2'h0, push};
      rd_ptr_q <= rd_ptr_q + {2'h0, pop};
      count_q <= count_d;
    end
  end

  // --------------------------------------------------------------------
  // Transmit sequencer
  // --------------------------------------------------------------------
  tx_state_t state_q, state_d;
  logic [8:0] cnt_q, cnt_d;
  logic [4:0] bit_q, bit_d;
  logic [31:0] shift_q, shift_d;
  wire [8:0] half_len = tx_rate_select_bit ? `AWT_HALF_LO : `AWT_HALF_HI;
  wire [8:0] gap_len = tx_rate_select_bit ? `AWT_GAP_LO : `AWT_GAP_HI;
  wire tx_word_t top_word = mem_q[rd_ptr_q];
  wire parity_bit = ~(^top_word) ^ parity_invert_bit;
  wire cnt_end = (cnt_q == 9'h000);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_end ? 9'h000 : cnt_q - 9'h001;
    bit_d = bit_q;
    shift_d = shift_q;
    pop = 1'b0;
    case (state_q)
      TX_IDLE: begin
        if (transmit_enable && !fifo_empty) begin
          pop = 1'b1;
          shift_d = {parity_bit, top_word};
          bit_d = 5'h00;
          cnt_d = half_len - 9'h001;
          state_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (cnt_end) begin
          cnt_d = half_len - 9'h001;
          state_d = TX_NULL;
        end
      end
      TX_NULL: begin
        if (cnt_end) begin
          if (bit_q == `AWT_LAST_BIT) begin
            cnt_d = gap_len - 9'h001;
            state_d = TX_GAP;
          end else begin
            bit_d = bit_q + 5'h01;
            shift_d = {1'b0, shift_q[31:1]};
            cnt_d = half_len - 9'h001;
            state_d = TX_DATA;
          end
        end
      end
      TX_GAP: begin
        if (cnt_end) begin
          state_d = TX_IDLE;
        end
      end
      default: begin
        state_d = TX_IDLE;
      end
    endcase
    // Dropping enable mid-word abandons the word that was already popped
    if (!transmit_enable && state_q != TX_IDLE) begin
      state_d = TX_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= TX_IDLE;
      cnt_q <= 9'h000;
      bit_q <= 5'h00;
      shift_q <= 32'h00000000;
      serial_out_true <= 1'b0;
      serial_out_comp <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      // Both lines low is the null level
      serial_out_true <= (state_d == TX_DATA) && shift_d[0];
      serial_out_comp <= (state_d == TX_DATA) && !shift_d[0];
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign tx_ready = fifo_empty && (state_q == TX_IDLE);
  assign line_out_a = serial_out_true;
  assign line_out_b = serial_out_comp;
  assign line_slope_slow = tx_rate_select_bit;
  assign rx1_logic_true = loopback_test_bit ? rx1_line_true : serial_out_true;
  assign rx1_logic_comp = loopback_test_bit ? rx1_line_comp : serial_out_comp;
  assign rx2_logic_true = loopback_test_bit ? rx2_line_true : serial_out_true;
  assign rx2_logic_comp = loopback_test_bit ? rx2_line_comp : serial_out_comp;

  wire [15:0] stat_word = {8'h00, avail_q[1], avail_q[0], state_q != TX_IDLE, count_q, tx_ready};
  wire [15:0] rd_mux = (reg_addr == `AWT_CTRL_ADDR) ? ctrl_q :
                       (reg_addr == `AWT_STAT_ADDR) ? stat_word : 16'h0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 16'h0000;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_full_drop;
    @(posedge clk) disable iff (!resetn)
      (host_push && fifo_full && !pop) |=> (count_q == 4'(`AWT_FIFO_DEPTH));
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("load into full FIFO changed count");

  property p_load_count;
    @(posedge clk) disable iff (!resetn)
      (push && !pop) |=> (count_q == $past(count_q) + 4'h1);
  endproperty
  a_load_count: assert property (p_load_count) else $error("load did not add a word");

  property p_no_half_load;
    @(posedge clk) disable iff (!resetn)
      (pl2_rise && !byte1_valid_q && !rep_push && !pop) |=> $stable(count_q);
  endproperty
  a_no_half_load: assert property (p_no_half_load) else $error("second byte alone loaded");

  property p_ready_drop;
    @(posedge clk) disable iff (!resetn)
      host_push && !fifo_full |=> !tx_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready still high after load");

  property p_first_bit;
    @(posedge clk) disable iff (!resetn)
      (state_q == TX_IDLE && pop) |=> (serial_out_true ^ serial_out_comp);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit late");

  property p_hi_half;
    @(posedge clk) disable iff (!resetn)
      ($rose(state_q == TX_DATA) && !tx_rate_select_bit && transmit_enable) ##1
      transmit_enable [*4] |=> $past(state_q == TX_DATA) && (state_q == TX_NULL);
  endproperty
  a_hi_half: assert property (p_hi_half) else $error("high speed data half not 5 clocks");

  property p_null_idle;
    @(posedge clk) disable iff (!resetn)
      (state_q == TX_IDLE || state_q == TX_GAP) |-> !serial_out_true && !serial_out_comp;
  endproperty
  a_null_idle: assert property (p_null_idle) else $error("line not null while idle");

  property p_parity;
    @(posedge clk) disable iff (!resetn)
      (state_q == TX_IDLE && pop) |=> ((^shift_q) == !$past(parity_invert_bit));
  endproperty
  a_parity: assert property (p_parity) else $error("transmit parity wrong");

  property p_avail_clear;
    @(posedge clk) disable iff (!resetn)
      (rx1_read_strobe && !rx1_word_done && !got_lo_q[0] && !got_hi_q[0]) |=>
      (rx1_word_available == $past(rx1_word_available));
  endproperty
  a_avail_clear: assert property (p_avail_clear) else $error("one byte cleared availability");

  property p_loop;
    @(posedge clk) disable iff (!resetn)
      !loopback_test_bit |-> (rx2_logic_true == serial_out_true) && (rx1_logic_comp == serial_out_comp);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not routed");

  c_word_sent: cover property (@(posedge clk) disable iff (!resetn) $rose(state_q == TX_GAP));
  c_full: cover property (@(posedge clk) disable iff (!resetn) fifo_full && host_push);
  c_repeat: cover property (@(posedge clk) disable iff (!resetn) rep_push && push);
endmodule : arinc_word_transmitter
`default_nettype wire

// file: tb/arinc_host_model.sv
// Host processor model driving the register port, FIFO loads, enable and receive reads
`timescale 1ns/1ns
`default_nettype none
module arinc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Transmit load and receive reads
  output logic [15:0] load_data,
  output logic first_byte_load_strobe,
  output logic second_byte_load_strobe,
  output logic transmit_enable,
  output logic rx1_read_strobe,
  output logic rx2_read_strobe,
  output logic rx_byte_sel,
  input wire logic [15:0] rx_read_data
);
  initial begin
    {reg_addr, reg_wdata, reg_write, reg_read, load_data} = '0;
    {first_byte_load_strobe, second_byte_load_strobe, transmit_enable} = '0;
    {rx1_read_strobe, rx2_read_strobe, rx_byte_sel} = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Byte 1 always goes first; a released bus shows the inverse of the last byte
  task automatic load(input logic [15:0] b1, input logic [15:0] b2);
    @(posedge clk);
    load_data <= b1;
    first_byte_load_strobe <= 1'b1;
    @(posedge clk);
    first_byte_load_strobe <= 1'b0;
    @(posedge clk);
    load_data <= b2;
    second_byte_load_strobe <= 1'b1;
    @(posedge clk);
    second_byte_load_strobe <= 1'b0;
    load_data <= ~b2;
  endtask : load
  task automatic en(input logic v);
    @(posedge clk);
    transmit_enable <= v;
  endtask : en
  // Reads are issued at once, well inside one word period
  task automatic rxr(input logic n, input logic s, output logic [15:0] d);
    @(posedge clk);
    rx_byte_sel <= s;
    rx1_read_strobe <= ~n;
    rx2_read_strobe <= n;
    @(posedge clk);
    rx1_read_strobe <= 1'b0;
    rx2_read_strobe <= 1'b0;
    #1 d = rx_read_data;
  endtask : rxr
endmodule : arinc_host_model
`default_nettype wire

// file: tb/arinc_word_transmitter_tb.sv
// Self-checking testbench of the ARINC word transmitter
`timescale 1ns/1ns
`default_nettype none
`include "arinc_word_transmitter_map.svh"
module arinc_word_transmitter_tb;
  logic clk, resetn, reg_write, reg_read, pl1, pl2, tx_en, rd1, rd2, sel;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, load_data, rx_read_data;
  logic [31:0] rx1_word, rx2_word;
  logic rx1_word_done, rx2_word_done, rx1_line_true, rx1_line_comp, rx2_line_true;
  logic rx2_line_comp, rx1_logic_true, rx1_logic_comp, rx2_logic_true, rx2_logic_comp;
  logic tx_ready, rx1_word_available, rx2_word_available, serial_out_true, serial_out_comp;
  logic line_out_a, line_out_b, line_slope_slow;
  int err_total = 0;
  int checked = 0;
  arinc_word_transmitter dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .load_data(load_data), .first_byte_load_strobe(pl1), .second_byte_load_strobe(pl2),
    .transmit_enable(tx_en), .tx_ready(tx_ready), .rx1_word(rx1_word), .rx2_word(rx2_word),
    .rx1_word_done(rx1_word_done), .rx2_word_done(rx2_word_done), .rx1_read_strobe(rd1),
    .rx2_read_strobe(rd2), .rx_byte_sel(sel), .rx_read_data(rx_read_data),
    .rx1_word_available(rx1_word_available), .rx2_word_available(rx2_word_available),
    .rx1_line_true(rx1_line_true), .rx1_line_comp(rx1_line_comp),
    .rx2_line_true(rx2_line_true), .rx2_line_comp(rx2_line_comp),
    .rx1_logic_true(rx1_logic_true), .rx1_logic_comp(rx1_logic_comp),
    .rx2_logic_true(rx2_logic_true), .rx2_logic_comp(rx2_logic_comp),
    .serial_out_true(serial_out_true), .serial_out_comp(serial_out_comp),
    .line_out_a(line_out_a), .line_out_b(line_out_b), .line_slope_slow(line_slope_slow));
  arinc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .load_data(load_data),
    .first_byte_load_strobe(pl1), .second_byte_load_strobe(pl2), .transmit_enable(tx_en),
    .rx1_read_strobe(rd1), .rx2_read_strobe(rd2), .rx_byte_sel(sel),
    .rx_read_data(rx_read_data));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  function automatic logic [15:0] lo_byte(input logic [31:0] w);
    lo_byte = {w[12:8], w[30], w[29], w[31], w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
  endfunction : lo_byte
  function automatic logic [31:0] xw(input logic [31:0] w, input logic inv);
    xw = {inv ~^ (^w[30:0]), w[30:0]};
  endfunction : xw
  // Measures every half bit; the tail null run ends at the next word or at ready
  task automatic send(input int h, input int g, input logic [31:0] exp);
    logic [31:0] w;
    int n;
    n = 0;
    while (!(serial_out_true | serial_out_comp) && n < 1000) begin
      tick;
      n++;
    end
    chk(n <= 5 * h, 1);
    for (int i = 0; i < 32; i++) begin
      w[i] = serial_out_true;
      chk(serial_out_true ^ serial_out_comp, 1);
      chk({line_out_a, line_out_b}, {serial_out_true, serial_out_comp});
      n = 0;
      while ((serial_out_true | serial_out_comp) && n < 100) begin
        tick;
        n++;
      end
      chk(n, h);
      n = 0;
      while (!(serial_out_true | serial_out_comp) && !tx_ready && n < 1000) begin
        tick;
        n++;
      end
      chk(i < 31 ? n == h : (n >= h + g && n <= h + g + 3), 1);
    end
    chk(w, exp);
  endtask : send
  task automatic rx_done(input logic n, input logic [31:0] w);
    @(posedge clk);
    rx1_word <= w;
    rx2_word <= w;
    rx1_word_done <= ~n;
    rx2_word_done <= n;
    @(posedge clk);
    rx1_word_done <= 1'b0;
    rx2_word_done <= 1'b0;
  endtask : rx_done
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_reset;
    logic [15:0] d;
    chk({tx_ready, serial_out_true, serial_out_comp, line_slope_slow}, 4'h8);
    host.rd(`AWT_CTRL_ADDR, d);
    chk(d, `AWT_CTRL_RESET);
    host.wr(`AWT_STAT_ADDR, 16'hFFFF);
    host.rd(`AWT_STAT_ADDR, d);
    chk(d, 16'h0001);
    host.rd(4'hF, d);
    chk(d, 16'h0000);
  endtask : sc_reset
  task automatic sc_basic(input logic inv, input logic rate);
    logic [15:0] d;
    logic [31:0] w;
    w = 32'h2B3C_4D5E ^ {16'h0000, inv, rate, 14'h0000};
    host.wr(`AWT_CTRL_ADDR, {2'b00, rate, inv, 12'h020});
    host.load(lo_byte(w), w[28:13]);
    tick;
    chk(tx_ready, 0);
    chk(line_slope_slow, rate);
    host.rd(`AWT_STAT_ADDR, d);
    chk(d, 16'h0002);
    host.en(1'b1);
    send(rate ? `AWT_HALF_LO : `AWT_HALF_HI, rate ? `AWT_GAP_LO : `AWT_GAP_HI, xw(w, inv));
    host.en(1'b0);
    host.rd(`AWT_STAT_ADDR, d);
    chk(d, 16'h0001);
  endtask : sc_basic
  task automatic sc_full;
    logic [15:0] d;
    logic [31:0] w;
    host.wr(`AWT_CTRL_ADDR, 16'h0020);
    for (int i = 0; i < 9; i++) begin
      w = 32'h1A5A_0F0F + i * 32'h0135_79BD;
      host.load(lo_byte(w), w[28:13]);
    end
    host.rd(`AWT_STAT_ADDR, d);
    chk(d, 16'h0010);
    host.en(1'b1);
    for (int i = 0; i < 8; i++) begin
      w = 32'h1A5A_0F0F + i * 32'h0135_79BD;
      send(`AWT_HALF_HI, `AWT_GAP_HI, xw(w, 1'b0));
    end
    host.en(1'b0);
    chk(tx_ready, 1);
  endtask : sc_full
  task automatic sc_loop;
    int n;
    host.wr(`AWT_CTRL_ADDR, 16'h0000);
    host.load(16'h8100, 16'h8001);
    host.en(1'b1);
    repeat (120) begin
      tick;
      chk({rx1_logic_true, rx1_logic_comp, rx2_logic_true, rx2_logic_comp},
        {2{serial_out_true, serial_out_comp}});
    end
    n = 0;
    while (!tx_ready && n < 1000) begin
      tick;
      n++;
    end
    host.en(1'b0);
    host.wr(`AWT_CTRL_ADDR, 16'h0020);
    tick;
    chk({rx1_logic_true, rx1_logic_comp, rx2_logic_true, rx2_logic_comp}, 4'h9);
    @(posedge clk);
    {rx1_line_true, rx1_line_comp, rx2_line_true, rx2_line_comp} <= 4'h6;
    tick;
    chk({rx1_logic_true, rx1_logic_comp, rx2_logic_true, rx2_logic_comp}, 4'h6);
  endtask : sc_loop
  task automatic sc_rx;
    logic [15:0] d;
    host.wr(`AWT_CTRL_ADDR, 16'h0060);
    rx_done(1'b0, 32'hC3A5_9617);
    tick;
    chk({rx1_word_available, rx2_word_available}, 2'b10);
    host.rxr(1'b0, 1'b0, d);
    chk(d, lo_byte(32'hC3A5_9617));
    chk(rx1_word_available, 1);
    host.rxr(1'b0, 1'b1, d);
    chk(d, 16'h1D2C);
    chk(rx1_word_available, 0);
    host.rd(`AWT_STAT_ADDR, d);
    chk(d, 16'h0002);
    host.en(1'b1);
    send(`AWT_HALF_HI, `AWT_GAP_HI, xw(32'hC3A5_9617, 1'b0));
    host.en(1'b0);
    host.wr(`AWT_CTRL_ADDR, 16'h0020);
    rx_done(1'b1, 32'h5E6F_7081);
    host.rxr(1'b1, 1'b1, d);
    chk(d, 16'hF37B);
    chk(rx2_word_available, 1);
    host.rxr(1'b1, 1'b0, d);
    chk(d, lo_byte(32'h5E6F_7081));
    chk({rx2_word_available, tx_ready}, 2'b01);
  endtask : sc_rx
  // ----------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    err_total++;
    wrap_up;
  end
  initial begin
    resetn = 1'b0;
    {rx1_word, rx2_word, rx1_word_done, rx2_word_done} = '0;
    {rx1_line_true, rx1_line_comp, rx2_line_true, rx2_line_comp} = 4'h9;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tick;
    sc_reset;
    sc_basic(1'b0, 1'b0);
    sc_basic(1'b1, 1'b0);
    sc_basic(1'b0, 1'b1);
    sc_full;
    sc_loop;
    sc_rx;
    wrap_up;
  end
endmodule : arinc_word_transmitter_tb
`default_nettype wire
